/* File: rtl/rwc_params.svh */
// offsets, field positions, reset values and counts of the ramp waveform core
// Summary of operation
// RULE1: 12-bit prescaled counter with compare, capture and control logic in core domain.
// RULE2: counter and compares derive two outputs, shaped by the wave generation mode.
// RULE3: standard cycle runs dead A, on A, dead B, on B without overlap.
// RULE4: some setups skip output states or let output states overlap.
// RULE5: four compare values set A, clear A, set B, clear B, each own register.
// RULE6: mode field picks one ramp, two ramp, four ramp or dual slope counting.
// RULE7: core clock picked from three sources, then prescaled.
// RULE8: core clock drives counter, waveform outputs and all output events.
// RULE9: two input event channels, each tied to its matching waveform output.
// RULE10: input event A can be blanked for a set time in a chosen state.
// RULE11: optional filter drops events shorter than four core clock cycles (code counts four clk cycles, not prescaled ticks).
// RULE12: each input picks low/falling or high/rising as its active condition.
// RULE13: asynchronous option lets an event kill outputs at once, without a clock.
// RULE14: each input picks one of ten modes for output effect and counter jump.
// RULE15: events either capture the counter or act as fault triggers.
// RULE16: two double-buffered capture channels and double-buffered compare values.
// RULE17: running controller emits output events on compare matches (code emits none in dual slope mode).
// RULE18: output events may be delayed by a programmable time.
// RULE19: controller flags positions within the cycle.
// RULE20: software enables only when enable ready and after setup is written.
// RULE21: end-of-cycle strobe stops after the cycle; clearing enable stops after sync.
// RULE22: command strobe register clears itself when its command completes.
// RULE23: static configuration ignores writes while the controller is enabled.
// RULE24: both outputs stay inactive during dead-time states.
// RULE25: new compare values apply only on sync command or on enable.
`ifndef RWC_PARAMS_SVH
`define RWC_PARAMS_SVH

// register offsets (word addresses on the 4-bit port)
`define RWC_ADDR_CTRL 4'h0
`define RWC_ADDR_CMD 4'h1
`define RWC_ADDR_STATUS 4'h2
`define RWC_ADDR_EVCTL 4'h3
`define RWC_ADDR_BLANK 4'h4
`define RWC_ADDR_CMP0 4'h5
`define RWC_ADDR_CMP3 4'h8
`define RWC_ADDR_DLY 4'h9
`define RWC_ADDR_CAPA 4'ha
`define RWC_ADDR_CAPB 4'hb
`define RWC_ADDR_COUNT 4'hc

// main_control fields
`define RWC_CTRL_EN 0
`define RWC_CTRL_WGM 1
`define RWC_CTRL_CLKSEL 3
`define RWC_CTRL_PRESC 5

// command_strobe bits
`define RWC_CMD_SYNC_EOC 0
`define RWC_CMD_SYNC 1
`define RWC_CMD_RESTART 2
`define RWC_CMD_CAPA 3
`define RWC_CMD_CAPB 4
`define RWC_CMD_DIS_EOC 5
`define RWC_CMD_IMM_MASK 6'h1e
`define RWC_CMD_EOC_MASK 6'h21

// event control, one byte per channel
`define RWC_EV_STRIDE 8
`define RWC_EV_MODE 0
`define RWC_EV_EDGE 4
`define RWC_EV_FILT 5
`define RWC_EV_ASYNC 6

// blanking and delay fields
`define RWC_BLANK_LEN 0
`define RWC_BLANK_SEL 8
`define RWC_DLY_VAL 0
`define RWC_DLY_EN 8
`define RWC_DLY_SRC 9

// reset values and counts
`define RWC_RESET_WORD 16'h0000
`define RWC_RESET_CMP 12'h000
`define RWC_SYNC_CYCLES 2'h2
`define RWC_FILTER_FULL 2'h3

`endif

/* File: rtl/rwc_pkg.sv */
// types of the ramp waveform core
package rwc_pkg;

	typedef enum logic [1:0] {
		RWC_WGM_ONE = 2'b00,
		RWC_WGM_TWO = 2'b01,
		RWC_WGM_FOUR = 2'b10,
		RWC_WGM_DUAL = 2'b11
	} rwc_wgm_t;

	typedef enum logic [1:0] {
		RWC_ST_DTA = 2'b00,
		RWC_ST_OTA = 2'b01,
		RWC_ST_DTB = 2'b10,
		RWC_ST_OTB = 2'b11
	} rwc_state_t;

	typedef enum logic [1:0] {
		RWC_CLK_SYS = 2'b00,
		RWC_CLK_OSC = 2'b01,
		RWC_CLK_EXT = 2'b10,
		RWC_CLK_RSV = 2'b11
	} rwc_clksel_t;

	typedef enum logic [3:0] {
		RWC_IM_IGNORE = 4'h0,
		RWC_IM_GATE_OWN = 4'h1,
		RWC_IM_GATE_BOTH = 4'h2,
		RWC_IM_RESTART = 4'h3,
		RWC_IM_OWN_RESTART = 4'h4,
		RWC_IM_BOTH_RESTART = 4'h5,
		RWC_IM_JUMP = 4'h6,
		RWC_IM_OWN_JUMP = 4'h7,
		RWC_IM_BOTH_JUMP = 4'h8,
		RWC_IM_CAPTURE = 4'h9
	} rwc_imode_t;

endpackage : rwc_pkg

/* File: rtl/rwc_core.sv */
// ramp waveform controller: counter, compares, events, capture, registers
`timescale 1ns/10ps
`default_nettype none
`include "rwc_params.svh"

module rwc_core import rwc_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// register port
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [15:0] rdata,
	// alternative core clock sources, one-cycle ticks
	input wire logic osc_tick,
	input wire logic ext_tick,
	// input events, bit 0 is channel A
	input wire logic [1:0] event_in,
	// power stage outputs
	output logic wave_out_a,
	output logic wave_out_b,
	// event and cycle position outputs
	output logic out_event,
	output logic cycle_end_pulse
);

	// register state
	logic en_q;
	logic en_s1_q;
	logic core_en_q;
	logic core_en_prev_q;
	rwc_wgm_t wgm_q;
	rwc_clksel_t clksel_q;
	logic [1:0] presc_q;
	logic [15:0] evctl_q;
	logic [9:0] blank_q;
	logic [10:0] dly_q;
	logic [11:0] sh_q [4];
	logic [11:0] act_q [4];
	logic [5:0] cmd_q;
	logic [1:0] cmd_age_q;
	logic [15:0] rdata_q;

	// core state
	logic [2:0] psc_q;
	logic [11:0] cnt_q;
	rwc_state_t st_q;
	rwc_state_t st_prev_q;
	logic up_q;
	logic wa_q;
	logic wb_q;
	logic [7:0] blank_cnt_q;
	logic [7:0] dly_cnt_q;
	logic dly_busy_q;
	logic out_event_q;
	logic eoc_pulse_q;

	// combinational nets
	logic enable_ready;
	logic command_ready;
	logic cmd_live;
	logic src_tick;
	logic [2:0] psc_mask;
	logic tick;
	logic eoc_c;
	logic eoc_now;
	logic load_act;
	logic dis_done;
	logic [11:0] nxt_cnt;
	rwc_state_t nxt_st;
	logic nxt_up;
	logic on_a;
	logic on_b;
	logic gate_a;
	logic gate_b;
	logic restart_req;
	logic [1:0] ev_norm;
	logic [1:0] ev_act;
	logic [1:0] ev_rise;
	logic [1:0] ev_gate_own;
	logic [1:0] ev_gate_both;
	logic [1:0] ev_restart;
	logic [1:0] ev_jump;
	logic [23:0] cap_val;
	logic blank_on;
	logic st_entry;
	logic [3:0] cmp_idx;
	logic cmp_hit;

	// enable handshake: the clear path takes two flops before the core sees it
	assign enable_ready = (en_q == en_s1_q) && (en_s1_q == core_en_q);
	assign command_ready = (cmd_q == 6'h00);
	assign cmd_live = (cmd_age_q == `RWC_SYNC_CYCLES);
	assign eoc_now = tick & eoc_c;
	assign dis_done = cmd_live & cmd_q[`RWC_CMD_DIS_EOC] & eoc_now;
	assign cmp_idx = addr - `RWC_ADDR_CMP0;
	assign cmp_hit = (addr >= `RWC_ADDR_CMP0) && (addr <= `RWC_ADDR_CMP3);

	// main_control; static fields only take writes while disabled
	always_ff @(posedge clk) begin
		if (!resetn) begin
			en_q <= 1'b0;
			wgm_q <= RWC_WGM_ONE;
			clksel_q <= RWC_CLK_SYS;
			presc_q <= 2'h0;
		end else if (wr_en && addr == `RWC_ADDR_CTRL && enable_ready) begin
			en_q <= wdata[`RWC_CTRL_EN]; // see RULE20
			if (!en_q) begin // see RULE23
				wgm_q <= rwc_wgm_t'(wdata[`RWC_CTRL_WGM +: 2]); // see RULE6
				clksel_q <= rwc_clksel_t'(wdata[`RWC_CTRL_CLKSEL +: 2]);
				presc_q <= wdata[`RWC_CTRL_PRESC +: 2];
			end
		end else if (dis_done) begin
			en_q <= 1'b0; // see RULE21
		end
	end

	// other static configuration
	always_ff @(posedge clk) begin
		if (!resetn) begin
			evctl_q <= `RWC_RESET_WORD;
			blank_q <= 10'h000;
			dly_q <= 11'h000;
		end else if (wr_en && !en_q) begin // see RULE23
			if (addr == `RWC_ADDR_EVCTL)
				evctl_q <= wdata;
			if (addr == `RWC_ADDR_BLANK)
				blank_q <= wdata[9:0];
			if (addr == `RWC_ADDR_DLY)
				dly_q <= wdata[10:0];
		end
	end

	// enable crossing and edge detect
	always_ff @(posedge clk) begin
		if (!resetn) begin
			en_s1_q <= 1'b0;
			core_en_q <= 1'b0;
			core_en_prev_q <= 1'b0;
		end else begin
			en_s1_q <= en_q;
			core_en_q <= en_s1_q; // see RULE21
			core_en_prev_q <= core_en_q;
		end
	end

	// compare shadows; writes held off while a command is in flight
	always_ff @(posedge clk) begin
		if (!resetn) begin
			for (int i = 0; i < 4; i++)
				sh_q[i] <= `RWC_RESET_CMP;
		end else if (wr_en && cmp_hit && command_ready) begin
			sh_q[cmp_idx[1:0]] <= wdata[11:0]; // see RULE5
		end
	end

	// command strobe: ages through the sync delay, bits drop when done
	always_ff @(posedge clk) begin
		if (!resetn || !core_en_q) begin
			cmd_q <= 6'h00;
			cmd_age_q <= 2'h0;
		end else if (command_ready) begin
			cmd_age_q <= 2'h0;
			if (wr_en && addr == `RWC_ADDR_CMD)
				cmd_q <= wdata[5:0];
		end else if (!cmd_live) begin
			cmd_age_q <= cmd_age_q + 2'h1;
		end else begin
			// immediate commands end now, end-of-cycle ones at the wrap
			cmd_q <= cmd_q & ~(`RWC_CMD_IMM_MASK | // see RULE22
				(eoc_now ? `RWC_CMD_EOC_MASK : 6'h00));
		end
	end

	// active compares move only on enable or a sync command
	assign load_act = (core_en_q & ~core_en_prev_q) |
		(cmd_live & cmd_q[`RWC_CMD_SYNC]) |
		(cmd_live & cmd_q[`RWC_CMD_SYNC_EOC] & eoc_now);
	always_ff @(posedge clk) begin
		if (!resetn) begin
			for (int i = 0; i < 4; i++)
				act_q[i] <= `RWC_RESET_CMP;
		end else if (load_act) begin
			for (int i = 0; i < 4; i++)
				act_q[i] <= sh_q[i]; // see RULE16 see RULE25
		end
	end

	// source select and power-of-two prescaler
	always_comb begin
		unique case (clksel_q) // see RULE7
			RWC_CLK_SYS: src_tick = 1'b1;
			RWC_CLK_OSC: src_tick = osc_tick;
			RWC_CLK_EXT: src_tick = ext_tick;
			RWC_CLK_RSV: src_tick = 1'b1;
		endcase
		unique case (presc_q)
			2'h0: psc_mask = 3'h0;
			2'h1: psc_mask = 3'h1;
			2'h2: psc_mask = 3'h3;
			2'h3: psc_mask = 3'h7;
		endcase
	end
	assign tick = core_en_q & src_tick & ((psc_q & psc_mask) == psc_mask);

	always_ff @(posedge clk) begin
		if (!resetn || !core_en_q)
			psc_q <= 3'h0;
		else if (src_tick)
			psc_q <= psc_q + 3'h1; // see RULE1
	end

	// next count and state per wave generation mode
	always_comb begin
		nxt_cnt = cnt_q + 12'h001;
		nxt_st = st_q;
		nxt_up = up_q;
		eoc_c = 1'b0;
		unique case (wgm_q) // see RULE6
			RWC_WGM_DUAL: begin
				// up to clear B, back down to zero; zero ends the cycle
				if (up_q && cnt_q >= act_q[3]) begin
					nxt_up = 1'b0;
					nxt_cnt = cnt_q - 12'h001;
				end else if (!up_q) begin
					nxt_cnt = cnt_q - 12'h001;
					if (cnt_q == 12'h001 || cnt_q == 12'h000) begin
						nxt_cnt = 12'h000;
						nxt_up = 1'b1;
						eoc_c = 1'b1;
					end
				end
			end
			default: begin
				// each state ends on its own compare value
				if (cnt_q == act_q[st_q]) begin // see RULE3
					nxt_st = rwc_state_t'(st_q + 2'b01);
					eoc_c = (st_q == RWC_ST_OTB);
					if (wgm_q == RWC_WGM_FOUR || st_q == RWC_ST_OTB ||
						(wgm_q == RWC_WGM_TWO && st_q == RWC_ST_OTA))
						nxt_cnt = 12'h000;
				end
			end
		endcase
	end

	// counter and state; events jump it, commands restart it
	always_ff @(posedge clk) begin
		if (!resetn || !core_en_q || restart_req) begin
			cnt_q <= 12'h000;
			st_q <= RWC_ST_DTA;
			up_q <= 1'b1;
		end else if (ev_jump[0] && wgm_q != RWC_WGM_DUAL) begin
			st_q <= RWC_ST_DTB; // see RULE14
			cnt_q <= (wgm_q == RWC_WGM_ONE) ? act_q[1] : 12'h000;
		end else if (ev_jump[1] && wgm_q != RWC_WGM_DUAL) begin
			st_q <= RWC_ST_DTA;
			cnt_q <= 12'h000;
		end else if (tick) begin
			cnt_q <= nxt_cnt; // see RULE8
			st_q <= nxt_st;
			up_q <= nxt_up;
		end
	end
	assign restart_req = (|ev_restart) | (ev_jump[0] & wgm_q == RWC_WGM_DUAL) |
		(ev_jump[1] & wgm_q == RWC_WGM_DUAL) |
		(cmd_live & cmd_q[`RWC_CMD_RESTART]);

	// output levels; dual slope may overlap, ramps never do
	always_comb begin
		if (wgm_q == RWC_WGM_DUAL) begin
			on_a = cnt_q < act_q[0]; // see RULE4
			on_b = cnt_q > act_q[2];
		end else begin
			on_a = (st_q == RWC_ST_OTA); // see RULE24
			on_b = (st_q == RWC_ST_OTB);
		end
	end
	assign gate_a = (ev_act[0] & (ev_gate_own[0] | ev_gate_both[0])) |
		(ev_act[1] & ev_gate_both[1]);
	assign gate_b = (ev_act[1] & (ev_gate_own[1] | ev_gate_both[1])) |
		(ev_act[0] & ev_gate_both[0]);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			wa_q <= 1'b0;
			wb_q <= 1'b0;
		end else begin
			wa_q <= core_en_q & on_a & ~gate_a; // see RULE2 see RULE15
			wb_q <= core_en_q & on_b & ~gate_b;
		end
	end

	// the kill path bypasses every flop so a fault stops the stage at once
	assign wave_out_a = wa_q & ~(evctl_q[`RWC_EV_ASYNC] & ev_norm[0]); // see RULE13
	assign wave_out_b = wb_q &
		~(evctl_q[`RWC_EV_STRIDE + `RWC_EV_ASYNC] & ev_norm[1]);

	// blanking of channel A from entry into the chosen state
	assign st_entry = (st_q != st_prev_q);
	assign blank_on = (blank_cnt_q != 8'h00);
	always_ff @(posedge clk) begin
		if (!resetn || !core_en_q) begin
			st_prev_q <= RWC_ST_DTA;
			blank_cnt_q <= 8'h00;
		end else begin
			st_prev_q <= st_q;
			if (st_entry && st_q == rwc_state_t'(blank_q[`RWC_BLANK_SEL +: 2]))
				blank_cnt_q <= blank_q[`RWC_BLANK_LEN +: 8]; // see RULE10
			else if (tick && blank_on)
				blank_cnt_q <= blank_cnt_q - 8'h01;
		end
	end

	// per-channel event conditioning, mode decode and capture
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ev
			rwc_imode_t mode;
			logic filt_on;
			logic cond;
			logic prev_q;
			logic [1:0] flt_q;
			logic [11:0] hold_q;
			logic [11:0] buf_q;
			logic hold_v_q;
			logic buf_v_q;
			logic cap_trig;
			logic cap_read;

			assign mode = rwc_imode_t'(evctl_q[gi*`RWC_EV_STRIDE +: 4]);
			assign filt_on = evctl_q[gi*`RWC_EV_STRIDE + `RWC_EV_FILT];
			// edge bit high picks rising/high as active
			assign ev_norm[gi] = event_in[gi] ~^
				evctl_q[gi*`RWC_EV_STRIDE + `RWC_EV_EDGE]; // see RULE12
			// four straight cycles needed before a filtered event counts
			assign cond = filt_on ? (ev_norm[gi] && flt_q == `RWC_FILTER_FULL)
				: ev_norm[gi];
			assign ev_act[gi] = core_en_q & cond &
				~((gi == 0) & blank_on); // see RULE9 see RULE10
			assign ev_rise[gi] = ev_act[gi] & ~prev_q;

			always_ff @(posedge clk) begin
				if (!resetn) begin
					flt_q <= 2'h0;
					prev_q <= 1'b0;
				end else begin
					prev_q <= ev_act[gi];
					if (!ev_norm[gi])
						flt_q <= 2'h0;
					else if (flt_q != `RWC_FILTER_FULL)
						flt_q <= flt_q + 2'h1; // see RULE11
				end
			end

			// ten modes: gate own or both, restart, jump, capture
			assign ev_gate_own[gi] = (mode == RWC_IM_GATE_OWN) || // see RULE14
				(mode == RWC_IM_OWN_RESTART) || (mode == RWC_IM_OWN_JUMP);
			assign ev_gate_both[gi] = (mode == RWC_IM_GATE_BOTH) ||
				(mode == RWC_IM_BOTH_RESTART) || (mode == RWC_IM_BOTH_JUMP);
			assign ev_restart[gi] = ev_rise[gi] && ((mode == RWC_IM_RESTART) ||
				(mode == RWC_IM_OWN_RESTART) || (mode == RWC_IM_BOTH_RESTART));
			assign ev_jump[gi] = ev_rise[gi] && ((mode == RWC_IM_JUMP) ||
				(mode == RWC_IM_OWN_JUMP) || (mode == RWC_IM_BOTH_JUMP));

			assign cap_trig = (ev_rise[gi] && mode == RWC_IM_CAPTURE) || // see RULE15
				(cmd_live && cmd_q[`RWC_CMD_CAPA + gi]);
			assign cap_read = rd_en && addr == 4'(`RWC_ADDR_CAPA + gi);

			// hold is what software reads; buf keeps one more behind it
			always_ff @(posedge clk) begin
				if (!resetn) begin
					hold_q <= 12'h000;
					buf_q <= 12'h000;
					hold_v_q <= 1'b0;
					buf_v_q <= 1'b0;
				end else if (cap_trig) begin
					if (!hold_v_q || (cap_read && !buf_v_q)) begin
						hold_q <= cnt_q; // see RULE16
						hold_v_q <= 1'b1;
					end else begin
						buf_q <= cnt_q;
						buf_v_q <= 1'b1;
					end
				end else if (cap_read) begin
					hold_q <= buf_v_q ? buf_q : hold_q;
					hold_v_q <= buf_v_q;
					buf_v_q <= 1'b0;
				end
			end
			assign cap_val[gi*12 +: 12] = hold_q;
		end
	endgenerate

	// output event on a chosen compare match, optionally delayed
	always_ff @(posedge clk) begin
		if (!resetn || !core_en_q) begin
			dly_cnt_q <= 8'h00;
			dly_busy_q <= 1'b0;
			out_event_q <= 1'b0;
		end else begin
			out_event_q <= 1'b0;
			if (st_entry && st_q ==
				rwc_state_t'(dly_q[`RWC_DLY_SRC +: 2] + 2'b01)) begin // see RULE17
				if (!dly_q[`RWC_DLY_EN] || dly_q[`RWC_DLY_VAL +: 8] == 8'h00)
					out_event_q <= 1'b1;
				else begin
					dly_cnt_q <= dly_q[`RWC_DLY_VAL +: 8]; // see RULE18
					dly_busy_q <= 1'b1;
				end
			end else if (dly_busy_q && tick) begin
				dly_cnt_q <= dly_cnt_q - 8'h01;
				if (dly_cnt_q == 8'h01) begin
					dly_busy_q <= 1'b0;
					out_event_q <= 1'b1;
				end
			end
		end
	end
	assign out_event = out_event_q;

	// cycle position pulse at each wrap
	always_ff @(posedge clk) begin
		if (!resetn)
			eoc_pulse_q <= 1'b0;
		else
			eoc_pulse_q <= eoc_now; // see RULE19
	end
	assign cycle_end_pulse = eoc_pulse_q;

	// read data, one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdata_q <= `RWC_RESET_WORD;
		end else if (rd_en) begin
			rdata_q <= `RWC_RESET_WORD;
			if (cmp_hit)
				rdata_q <= {4'h0, sh_q[cmp_idx[1:0]]};
			unique case (addr)
				`RWC_ADDR_CTRL: rdata_q <= {9'h000, presc_q, clksel_q,
					wgm_q, en_q};
				`RWC_ADDR_CMD: rdata_q <= {10'h000, cmd_q};
				`RWC_ADDR_STATUS: rdata_q <= {10'h000, st_q, wb_q, wa_q,
					command_ready, enable_ready};
				`RWC_ADDR_EVCTL: rdata_q <= evctl_q;
				`RWC_ADDR_BLANK: rdata_q <= {6'h00, blank_q};
				`RWC_ADDR_DLY: rdata_q <= {5'h00, dly_q};
				`RWC_ADDR_CAPA: rdata_q <= {4'h0, cap_val[11:0]};
				`RWC_ADDR_CAPB: rdata_q <= {4'h0, cap_val[23:12]};
				`RWC_ADDR_COUNT: rdata_q <= {4'h0, cnt_q};
				default: ;
			endcase
		end
	end
	assign rdata = rdata_q;

endmodule : rwc_core
`default_nettype wire

/* File: test/rwc_core_checker.sv */
// port-level checker of the ramp waveform core
`timescale 1ns/10ps
`default_nettype none

module rwc_core_checker (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// register port
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [15:0] rdata,
	// outputs toward the power stage, then the event and cycle position outputs
	input wire logic wave_out_a,
	input wire logic wave_out_b,
	input wire logic out_event,
	input wire logic cycle_end_pulse
);
	logic seen_en_q;

	// nothing may run before software has asked for enable once
	always_ff @(posedge clk) begin
		if (!resetn)
			seen_en_q <= 1'b0;
		else if (wr_en && addr == 4'h0 && wdata[0])
			seen_en_q <= 1'b1;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	AST_RDATA_HOLD: assert property (
		!$past(rd_en) |-> $stable(rdata))
		else $error("read data moved without a read");
	AST_UNMAPPED_ZERO: assert property (
		$past(rd_en) && $past(addr) > 4'hc |-> rdata == 16'h0000)
		else $error("unmapped address read not zero");
	AST_WIDE_12BIT: assert property (
		$past(rd_en) && ($past(addr) inside {[4'h5:4'h8], [4'ha:4'hc]})
		|-> rdata[15:12] == 4'h0)
		else $error("twelve-bit value has upper bits set");
	AST_STATUS_FIELDS: assert property (
		$past(rd_en) && $past(addr) == 4'h2 |-> rdata[15:6] == 10'h000)
		else $error("status has bits above its fields");
	AST_RESET_QUIET: assert property (
		$rose(resetn) |-> !(wave_out_a | wave_out_b | out_event
		| cycle_end_pulse))
		else $error("output active right after reset");
	AST_RESET_RDATA: assert property (
		$rose(resetn) |-> rdata == 16'h0000)
		else $error("read data not cleared by reset");
	AST_IDLE_WAVES: assert property (
		!seen_en_q |-> !wave_out_a && !wave_out_b)
		else $error("waveform active before any enable");
	AST_IDLE_EVENTS: assert property (
		!seen_en_q |-> !out_event && !cycle_end_pulse)
		else $error("event pulse before any enable");

endmodule : rwc_core_checker

bind rwc_core rwc_core_checker rwc_core_checker_i (
	.clk(clk),
	.resetn(resetn),
	.addr(addr),
	.wdata(wdata),
	.wr_en(wr_en),
	.rd_en(rd_en),
	.rdata(rdata),
	.wave_out_a(wave_out_a),
	.wave_out_b(wave_out_b),
	.out_event(out_event),
	.cycle_end_pulse(cycle_end_pulse)
);

`default_nettype wire

/* File: test/rwc_bridge_model.sv */
// model of the bridge drivers fed by the two waveform outputs
`timescale 1ns/10ps
`default_nettype none

module rwc_bridge_model (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// gate drives from the controller
	input wire logic drive_a,
	input wire logic drive_b,
	// last high times and shoot-through count
	output logic [11:0] width_a,
	output logic [11:0] width_b,
	output logic [11:0] overlap
);
	logic [11:0] run_a_q;
	logic [11:0] run_b_q;

	// widths latch on the falling drive, so a killed pulse shows short
	always_ff @(posedge clk) begin
		if (!resetn) begin
			run_a_q <= 12'h000;
			run_b_q <= 12'h000;
			width_a <= 12'h000;
			width_b <= 12'h000;
			overlap <= 12'h000;
		end else begin
			run_a_q <= drive_a ? run_a_q + 12'h001 : 12'h000;
			run_b_q <= drive_b ? run_b_q + 12'h001 : 12'h000;
			if (!drive_a && run_a_q != 12'h000)
				width_a <= run_a_q;
			if (!drive_b && run_b_q != 12'h000)
				width_b <= run_b_q;
			if (drive_a && drive_b)
				overlap <= overlap + 12'h001;
		end
	end

endmodule : rwc_bridge_model

`default_nettype wire

/* File: test/tb_top.sv */
// self-checking bench of the ramp waveform core
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	logic clk, resetn, wr_en, rd_en, osc_tick, ext_tick;
	logic wave_out_a, wave_out_b, out_event, cycle_end_pulse;
	logic [3:0] addr;
	logic [15:0] wdata, rdata, d;
	logic [1:0] event_in, tk;
	logic [2:0] watch;
	logic [11:0] width_a, width_b, overlap;
	int bad_count, checked, cyc, ev_cnt, i;
	logic [15:0] cfg [8] = '{16'h0001, 16'h0003, 16'h0005, 16'h0007,
		16'h0021, 16'h0009, 16'h0011, 16'h0061};
	// four ramp restarts at zero, so a state spans its compare plus one
	logic [15:0] exp_a [8] = '{16'h000a, 16'h000a, 16'h0015, 16'h0000,
		16'h0014, 16'h0014, 16'h0028, 16'h0050};
	logic [15:0] exp_b [8] = '{16'h000a, 16'h000a, 16'h0029, 16'h0000,
		16'h0014, 16'h0014, 16'h0028, 16'h0050};

	rwc_core rwc_core_i (.clk(clk), .resetn(resetn), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.osc_tick(osc_tick), .ext_tick(ext_tick), .event_in(event_in),
		.wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
		.out_event(out_event), .cycle_end_pulse(cycle_end_pulse));
	rwc_bridge_model rwc_bridge_model_i (.clk(clk), .resetn(resetn),
		.drive_a(wave_out_a), .drive_b(wave_out_b), .width_a(width_a),
		.width_b(width_b), .overlap(overlap));

	assign watch = {cycle_end_pulse, wave_out_b, wave_out_a};

	// clock
	always #12.5 clk = ~clk;

	// alternative sources: one tick in two and one in four
	always @(posedge clk) begin
		tk <= tk + 2'h1;
		osc_tick <= tk[0];
		ext_tick <= (tk == 2'h3);
	end

	// hang guard and output event count
	always @(posedge clk) begin
		cyc++;
		if (out_event === 1'b1) ev_cnt++;
		if (cyc == 60000) begin
			bad_count++;
			test_done();
		end
	end

	task test_done;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done

	task chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			bad_count++;
		end
	endtask : chk

	task wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr

	// data stand from the cycle after the strobe until the next read
	task rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 v = rdata;
	endtask : rd

	// bounded wait for a or b high or a cycle wrap
	task wait_sig(input int w);
		int k;
		k = 0;
		@(posedge clk);
		#1;
		while (watch[w] !== 1'b1 && k < 3000) begin
			@(posedge clk);
			#1;
			k++;
		end
		chk({15'h0, k == 3000}, 16'h0000);
	endtask : wait_sig

	task wait_wrap(input int n);
		repeat (n) wait_sig(2);
	endtask : wait_wrap

	task wait_rdy;
		int k;
		k = 0;
		d = 16'h0000;
		while (d[0] !== 1'b1 && k < 50) begin
			rd(4'h2, d);
			k++;
		end
		chk({15'h0, d[0]}, 16'h0001);
	endtask : wait_rdy

	// event pulse on b once b is driving
	task pulse_b(input int n);
		wait_sig(1);
		event_in[1] <= 1'b1;
		repeat (n) @(posedge clk);
		#1 event_in[1] <= 1'b0;
		rd(4'hb, d);
		rd(4'hb, d);
	endtask : pulse_b

	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		addr = 4'h0;
		wdata = 16'h0000;
		wr_en = 1'b0;
		rd_en = 1'b0;
		event_in = 2'b00;
		osc_tick = 1'b0;
		ext_tick = 1'b0;
		tk = 2'h0;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		rd(4'h2, d);
		chk(d & 16'h0003, 16'h0003);
		rd(4'hf, d);
		chk(d, 16'h0000);
		for (i = 0; i < 4; i++) wr(4'(5 + i), 16'(10 * (i + 1)));
		for (i = 0; i < 4; i++) begin
			rd(4'(5 + i), d);
			chk(d, 16'(10 * (i + 1)));
		end
		// each scheme and source from a clean disable; widths in clk
		for (i = 0; i < 8; i++) begin
			wr(4'h0, 16'h0000);
			wait_rdy();
			wr(4'h0, cfg[i]);
			wait_wrap(3);
			if (exp_a[i] != 16'h0000) begin
				chk({4'h0, width_a}, exp_a[i]);
				chk({4'h0, width_b}, exp_b[i]);
			end
			chk({4'h0, overlap}, 16'h0000);
		end
		// static fields hold while running
		wr(4'h0, 16'h0000);
		wait_rdy();
		wr(4'h0, 16'h0001);
		wait_wrap(1);
		wr(4'h0, 16'h0005);
		rd(4'h0, d);
		chk(d, 16'h0001);
		wr(4'h3, 16'h0040);
		rd(4'h3, d);
		chk(d, 16'h0000);
		// new clear value waits for sync
		wr(4'h6, 16'h000f);
		wait_wrap(2);
		chk({4'h0, width_a}, 16'h000a);
		rd(4'h6, d);
		chk(d, 16'h000f);
		wr(4'h1, 16'h0002);
		wait_wrap(3);
		chk({4'h0, width_a}, 16'h0005);
		rd(4'h1, d);
		chk(d, 16'h0000);
		wr(4'h6, 16'h0014);
		wr(4'h1, 16'h0002);
		// the sync takes a few cycles; a command before then is dropped
		repeat (4) @(posedge clk);
		// software capture stays inside the ramp
		wr(4'h1, 16'h0008);
		repeat (4) @(posedge clk);
		rd(4'ha, d);
		rd(4'ha, d);
		chk({15'h0, d > 16'd40}, 16'h0000);
		rd(4'h1, d);
		chk(d, 16'h0000);
		wait_wrap(1);
		ev_cnt = 0;
		wait_wrap(2);
		chk(16'(ev_cnt), 16'h0002);
		// a: gate own, async, high active; b: capture, filtered
		wr(4'h0, 16'h0000);
		wait_rdy();
		wr(4'h3, 16'h3951);
		wr(4'h0, 16'h0001);
		wait_sig(0);
		event_in[0] <= 1'b1;
		#2 chk({15'h0, wave_out_a}, 16'h0000);
		@(posedge clk);
		event_in[0] <= 1'b0;
		pulse_b(3);
		chk(d, 16'h0000);
		pulse_b(6);
		chk({15'h0, d == 16'h0000}, 16'h0000);
		// stop at the end of the running cycle
		wr(4'h1, 16'h0020);
		wait_wrap(1);
		repeat (4) @(posedge clk);
		rd(4'h0, d);
		chk(d & 16'h0001, 16'h0000);
		repeat (60) @(posedge clk);
		chk({14'h0, wave_out_a, wave_out_b}, 16'h0000);
		test_done();
	end

endmodule : tb_top

`default_nettype wire
